//--- hw/vpic_irq_ctrl.sv
// Video port frame interrupt enable set/clear logic with AXI4-Lite registers
//
// Function
// - One clear bit per channel, bits 0-3
// - Writing one disables that channel's interrupt
// - Clear acts only with base and set-enable
// - Writing zero changes no enable state
// - Raw mode: channel 1 picks line/frame by format
// - Effective clear resets set-enable bit internally
// - Status records syncs regardless of enables
`include "vpic_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module vpic_irq_ctrl #(
  parameter int CHANNELS = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [CHANNELS-1:0] frameSyncPin,
  input wire logic lineSyncPin,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irqReq
);
  logic [CHANNELS-1:0] baseEn_r;
  logic [CHANNELS-1:0] enSet_r;
  logic [CHANNELS-1:0] status_r;
  logic [1:0] chan0Format_r;
  logic [7:0] awAddr_r;
  logic awHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic wHeld_r;
  logic [CHANNELS-1:0] syncEvt;
  logic lineEvt;
  logic [CHANNELS-1:0] evt;
  vpic_pkg::vpic_events_t events;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_sync
      vpic_sync3 u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .pinIn(frameSyncPin[g]),
        .pulse(syncEvt[g])
      );
    end
  endgenerate

  vpic_sync3 u_line_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .pinIn(lineSyncPin),
    .pulse(lineEvt)
  );

  // Channel 1 source follows channel 0 capture format in raw mode
  always_comb begin
    events.frameSync = syncEvt;
    events.lineSync = {2'h0, lineEvt, 1'b0};
    evt = events.frameSync;
    if (chan0Format_r == `VPIC_FMT_RAW_LINE) begin
      evt[1] = events.lineSync[1];
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : hit

  logic doWrite;
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  logic [CHANNELS-1:0] wrOnes;
  assign wrOnes = s_axi_wdata_held(wData_r, wStrb_r);

  function automatic logic [CHANNELS-1:0] s_axi_wdata_held(input logic [31:0] d,
                                                         input logic [3:0] s);
    return s[0] ? d[CHANNELS-1:0] : '0;
  endfunction : s_axi_wdata_held

  // Write channel capture: address and data taken in either order
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `VPIC_RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_r[7:2] <= `VPIC_OFF_CHAN0_CONTROL >> 2) ?
                       `VPIC_RESP_OKAY : `VPIC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Readies built from next held and response state so the pins come from flops
      s_axi_awready <= !doWrite && !(awHeld_r || (s_axi_awvalid && s_axi_awready))
                       && !(s_axi_bvalid && !s_axi_bready);
      s_axi_wready <= !doWrite && !(wHeld_r || (s_axi_wvalid && s_axi_wready))
                      && !(s_axi_bvalid && !s_axi_bready);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      baseEn_r <= `VPIC_RST_EN;
      chan0Format_r <= `VPIC_FMT_FRAME;
    end else if (clkEn && doWrite) begin
      if (hit(awAddr_r, `VPIC_OFF_BASE_EN) && wStrb_r[0]) begin
        baseEn_r <= wData_r[CHANNELS-1:0];
      end
      if (hit(awAddr_r, `VPIC_OFF_CHAN0_CONTROL) && wStrb_r[0]) begin
        chan0Format_r <= wData_r[`VPIC_FMT_MSB:`VPIC_FMT_LSB];
      end
    end
  end

  // Set-enable: ones accepted only under base enable; clear wins only when effective
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enSet_r <= `VPIC_RST_EN;
    end else if (clkEn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (!baseEn_r[i]) begin
          enSet_r[i] <= 1'b0;
        end else if (doWrite && hit(awAddr_r, `VPIC_OFF_EN_SET) && wrOnes[i]) begin
          enSet_r[i] <= 1'b1;
        end else if (doWrite && hit(awAddr_r, `VPIC_OFF_EN_CLR) && wrOnes[i]
                     && enSet_r[i]) begin
          enSet_r[i] <= 1'b0;
        end
      end
    end
  end

  // Status keeps recording syncs whatever the enables; a new event beats a clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_r <= `VPIC_RST_EN;
    end else if (clkEn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (evt[i]) begin
          status_r[i] <= 1'b1;
        end else if (doWrite && hit(awAddr_r, `VPIC_OFF_STAT_CLR) && wrOnes[i]) begin
          status_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqReq <= 1'b0;
    end else if (clkEn) begin
      irqReq <= |(status_r & baseEn_r & enSet_r);
    end
  end

  // Read channel: one read outstanding, data registered
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `VPIC_RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `VPIC_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        // Clear and status-clear registers are write only and read zero
        if (hit(s_axi_araddr, `VPIC_OFF_BASE_EN)) begin
          s_axi_rdata[CHANNELS-1:0] <= baseEn_r;
        end else if (hit(s_axi_araddr, `VPIC_OFF_EN_SET)) begin
          s_axi_rdata[CHANNELS-1:0] <= enSet_r;
        end else if (hit(s_axi_araddr, `VPIC_OFF_STATUS)) begin
          s_axi_rdata[CHANNELS-1:0] <= status_r;
        end else if (hit(s_axi_araddr, `VPIC_OFF_CHAN0_CONTROL)) begin
          s_axi_rdata[`VPIC_FMT_MSB:`VPIC_FMT_LSB] <= chan0Format_r;
        end else if (!hit(s_axi_araddr, `VPIC_OFF_EN_CLR)
                     && !hit(s_axi_araddr, `VPIC_OFF_STAT_CLR)) begin
          s_axi_rresp <= `VPIC_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !(s_axi_arvalid && s_axi_arready) && !(s_axi_rvalid && !s_axi_rready);
    end
  end
endmodule : vpic_irq_ctrl
`default_nettype wire

//--- hw/vpic_cfg.svh
// Register offsets, field positions, reset values and response codes for the video port irq block
`ifndef VPIC_CFG_SVH
`define VPIC_CFG_SVH
`define VPIC_OFF_BASE_EN 8'h00
`define VPIC_OFF_EN_SET 8'h04
`define VPIC_OFF_EN_CLR 8'h08
`define VPIC_OFF_STATUS 8'h0C
`define VPIC_OFF_STAT_CLR 8'h10
`define VPIC_OFF_CHAN0_CONTROL 8'h14
`define VPIC_FMT_LSB 0
`define VPIC_FMT_MSB 1
`define VPIC_FMT_FRAME 2'h0
`define VPIC_FMT_RAW_LINE 2'h3
`define VPIC_RST_EN 4'h0
`define VPIC_RESP_OKAY 2'h0
`define VPIC_RESP_SLVERR 2'h2
`endif

//--- hw/vpic_pkg.sv
// Types shared by the video port irq block
package vpic_pkg;
  typedef struct packed {
    logic [3:0] frameSync;
    logic [3:0] lineSync;
  } vpic_events_t;
endpackage : vpic_pkg

//--- hw/vpic_sync3.sv
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
`default_nettype none
module vpic_sync3 (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic pinIn,
  output logic pulse
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end else if (clkEn) begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A change counts only once the last two stages agree
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
  assign pulse = clkEn && (s2_r == s3_r) && s3_r && !level_r;
endmodule : vpic_sync3
`default_nettype wire

//--- bench/vpic_irq_ctrl_assertions.sv
// Bus handshake and register read checks for the video port irq block
`include "vpic_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module vpic_irq_ctrl_assertions (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] rdAddr_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) rdAddr_r <= 8'h00;
    else if (clkEn && s_axi_arvalid && s_axi_arready) rdAddr_r <= s_axi_araddr;
  end
  default clocking @(posedge core_clk); endclocking
  // A frozen clock enable stalls every handshake, so no latency holds then
  default disable iff (!rst_n || !clkEn);
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid not held");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid not held");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready");
  chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("awready");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read late");
  chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write late");
  chk_clr_zero: assert property (s_axi_rvalid && rdAddr_r == `VPIC_OFF_EN_CLR |->
    s_axi_rdata == 32'h0) else $error("clear reg read");
  chk_unmapped_err: assert property (s_axi_rvalid &&
    rdAddr_r[7:2] > (`VPIC_OFF_CHAN0_CONTROL >> 2) |->
    s_axi_rresp == `VPIC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped");
  cov_write: cover property (s_axi_awvalid && s_axi_awready);
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == `VPIC_RESP_SLVERR);
  cov_bstall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule : vpic_irq_ctrl_assertions
bind vpic_irq_ctrl vpic_irq_ctrl_assertions chk (.core_clk, .rst_n, .clkEn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the video port irq block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb;
  logic core_clk = 0, rst_n = 0, clkEn = 1, lineSyncPin = 0;
  logic [3:0] frameSyncPin = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irqReq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0, cmp_count = 0, bs = 0, se = 0, st = 0, fm = 0, n;
  vpic_irq_ctrl dut (.core_clk, .rst_n, .clkEn, .frameSyncPin, .lineSyncPin, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irqReq);
  initial forever #10 core_clk = ~core_clk;
  task automatic summarize;
    $display("mismatches %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  function automatic logic [1:0] er(input logic [7:0] a);
    return a > 8'h14 ? 2'h2 : 2'h0;
  endfunction : er
  task automatic irq;
    repeat (3) @(posedge core_clk);
    `CHK("irqReq", (st & se) != 0, irqReq)
  endtask : irq
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1'($urandom);
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      s_axi_bready <= 1;
    end
    s_axi_bready <= 0;
    if (n == 50) begin num_errors++; summarize(); end
    `CHK("bresp", er(a), s_axi_bresp)
    // Low byte strobe off: the write is answered but changes nothing
    case (s_axi_wstrb[0] ? a : 8'hFF)
      8'h00: begin bs = d & 15; se &= bs; end
      8'h04: se |= d & bs & 15;
      8'h08: se &= ~d;
      8'h10: st &= ~d;
      8'h14: fm = d & 3;
      default: ;
    endcase
    irq();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    case (a)
      8'h00: e = 32'(bs);
      8'h04: e = 32'(se);
      8'h0C: e = 32'(st);
      8'h14: e = 32'(fm);
      default: e = 32'h0;
    endcase
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1'($urandom);
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_arready) s_axi_arvalid <= 0;
      s_axi_rready <= 1;
    end
    s_axi_rready <= 0;
    if (n == 50) begin num_errors++; summarize(); end
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er(a), s_axi_rresp)
  endtask : rd
  task automatic pin(input logic [3:0] f, input logic l);
    @(posedge core_clk);
    frameSyncPin <= f;
    lineSyncPin <= l;
    repeat (8) @(posedge core_clk);
    frameSyncPin <= 4'h0;
    lineSyncPin <= 0;
    st |= f & (fm == 3 ? 13 : 15);
    if (fm == 3 && l) st |= 2;
    repeat (8) @(posedge core_clk);
    irq();
    rd(8'h0C);
  endtask : pin
  initial begin
    void'($urandom(96));
    repeat (10) @(posedge core_clk);
    rst_n <= 1;
    for (int a = 0; a < 36; a += 4) rd(8'(a));
    $display("test reset done");
    wr(8'h04, 32'hF);
    pin(4'hF, 0);
    wr(8'h00, 32'hF);
    wr(8'h08, 32'hF);
    wr(8'h04, 32'hF);
    wr(8'h08, 32'h0);
    rd(8'h04);
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, 32'(1 << i));
      rd(8'h04);
    end
    $display("test clear done");
    s_axi_wstrb <= 4'hE;
    wr(8'h04, 32'hF);
    rd(8'h04);
    s_axi_wstrb <= 4'hF;
    wr(8'h00, $urandom);
    wr(8'h04, $urandom);
    pin(4'($urandom), 0);
    wr(8'h08, $urandom);
    wr(8'h10, 32'hF);
    $display("test random done");
    wr(8'h14, 32'h3);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h2);
    pin(4'h2, 0);
    pin(4'h0, 1);
    wr(8'h08, 32'h2);
    wr(8'h14, 32'h0);
    wr(8'h10, 32'hF);
    pin(4'h0, 1);
    wr(8'h20, 32'hF);
    $display("test raw mode done");
    wr(8'h00, 32'hF);
    wr(8'h04, 32'hF);
    // A sync pulse wholly inside a freeze must leave no trace
    clkEn <= 0;
    frameSyncPin <= 4'hF;
    repeat (6) @(posedge core_clk);
    frameSyncPin <= 4'h0;
    repeat (6) @(posedge core_clk);
    clkEn <= 1;
    repeat (8) @(posedge core_clk);
    rd(8'h0C);
    pin(4'h1, 0);
    rst_n <= 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    bs = 0;
    se = 0;
    st = 0;
    `CHK("irqReq", 1'b0, irqReq)
    rd(8'h00);
    rd(8'h04);
    rd(8'h0C);
    $display("test freeze reset done");
    summarize();
  end
endmodule : tb
`default_nettype wire
